// *** cio_regs.svh ***
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Word-indexed plain register port, 8-bit data
// Notes: Included by the design and the testbench
`ifndef CIO_REGS_SVH
`define CIO_REGS_SVH

// ****************
// Register offsets
// ****************
`define CIO_OFS_CONFIG 4'h0
`define CIO_OFS_STATUS 4'h1
`define CIO_OFS_PINREP 4'h2
`define CIO_OFS_IOBASE 4'h3

// ***************
// Field positions
// ***************
`define CIO_CFG_IFTYPE_LO 0
`define CIO_CFG_IFTYPE_HI 1
`define CIO_CFG_LEVEL 2
`define CIO_CFG_AUDIO 3
`define CIO_STS_SIGEN 0
`define CIO_STS_CHANGED 1
`define CIO_STS_INTPEND 2
`define CIO_IFTYPE_IO 2'h1

// ************
// Reset values
// ************
`define CIO_CONFIG_RST 8'h00
`define CIO_IOBASE_RST 8'h00

// *************
// Timing counts
// *************
`define CIO_CLK_PERIOD_NS 40
`define CIO_IRQ_PULSE_NS 500
`define CIO_IRQ_PULSE_CYC \
   ((`CIO_IRQ_PULSE_NS + `CIO_CLK_PERIOD_NS - 1) / `CIO_CLK_PERIOD_NS)

`endif

// *** cio_pkg.sv ***
// Purpose: Types shared by the card pin block
// Assumes: Constants live in cio_regs.svh
// Notes: Types only
package cio_pkg;
   typedef logic [7:0] cio_byte_t;
   typedef enum logic [1:0] {
      CIO_IRQ_IDLE = 2'b01,
      CIO_IRQ_PULSE = 2'b10
   } cio_irq_state_e;
endpackage : cio_pkg

// *** cio_card_io.sv ***
// Purpose: Card-side pin replacement, interrupt, audio, status and read steering
// Assumes: Host pins are asynchronous and pass two flip-flops
// Notes: All pin outputs come from flip-flops
`timescale 1ns/100ps
`default_nettype none
`include "cio_regs.svh"

module cio_card_io #(
   parameter int IO_AW = 10,
   parameter bit WIDE_PORT = 1'b1,
   parameter bit PULSE_SUPPORT = 1'b1,
   parameter bit AUDIO_SUPPORT = 1'b1,
   parameter bit STATUS_SUPPORT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire cio_pkg::cio_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output cio_pkg::cio_byte_t reg_rdata,
   // Card function side, same clock
   input wire logic irq_request,
   input wire logic audio_in,
   input wire logic ready_busy_in,
   input wire logic battery_detect_1,
   input wire logic battery_detect_2,
   input wire logic wprot_in,
   input wire cio_pkg::cio_byte_t mem_even_byte,
   input wire cio_pkg::cio_byte_t mem_odd_byte,
   // Host pins, asynchronous
   input wire logic card_reset,
   input wire logic low_byte_enable_n,
   input wire logic high_byte_enable_n,
   input wire logic byte_addr_bit,
   input wire logic attr_select_n,
   input wire logic out_enable_n,
   input wire logic io_read_n,
   input wire logic [IO_AW-1:0] io_addr,
   // Pin outputs
   output logic wide_port_ind_n,
   output logic ready_busy_line,
   output logic binary_audio_n,
   output logic status_changed_n,
   output logic input_ack_n,
   output logic [15:0] data_out,
   output logic data_oe_lo,
   output logic data_oe_hi
);
   import cio_pkg::*;

   localparam int NPIN = 7 + IO_AW;
   localparam logic [4:0] PULSE_CYC = 5'(`CIO_IRQ_PULSE_CYC);
   localparam logic [NPIN-1:0] PIN_IDLE = {{IO_AW{1'b0}}, 7'h76};

   // ***********************************
   // Pin synchronisers
   // ***********************************
   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_sync;
   wire [NPIN-1:0] pin_raw = {io_addr, io_read_n, out_enable_n, attr_select_n,
      byte_addr_bit, high_byte_enable_n, low_byte_enable_n, card_reset};

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         // Idle pin levels, so no false select shows after reset
         pin_meta <= PIN_IDLE;
         pin_sync <= PIN_IDLE;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   wire rst_s = pin_sync[0];
   wire lo_en_n_s = pin_sync[1];
   wire hi_en_n_s = pin_sync[2];
   wire byte_sel_s = pin_sync[3];
   wire reg_n_s = pin_sync[4];
   wire oe_n_s = pin_sync[5];
   wire iord_n_s = pin_sync[6];
   wire [IO_AW-1:0] ioa_s = pin_sync[NPIN-1:7];

   // ***********************************
   // Configuration registers
   // ***********************************
   cio_byte_t config_reg;
   cio_byte_t io_base;
   logic sig_enable;
   logic int_pending;
   logic [3:0] change_bits;
   logic [3:0] prev_levels;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire wr_cfg = reg_wr && hit(reg_addr, `CIO_OFS_CONFIG);
   wire wr_sts = reg_wr && hit(reg_addr, `CIO_OFS_STATUS);
   wire wr_pin = reg_wr && hit(reg_addr, `CIO_OFS_PINREP);
   wire wr_iob = reg_wr && hit(reg_addr, `CIO_OFS_IOBASE);

   wire [1:0] interface_type_field = config_reg[`CIO_CFG_IFTYPE_HI:`CIO_CFG_IFTYPE_LO];
   wire io_mode = (interface_type_field == `CIO_IFTYPE_IO);
   // Pulsed mode only if supported; otherwise level is forced
   wire level_mode = config_reg[`CIO_CFG_LEVEL] || !PULSE_SUPPORT;
   wire audio_enable = config_reg[`CIO_CFG_AUDIO];

   // Card reset restores memory-only use
   always_ff @(posedge ref_clk) begin
      if (!reset_n || rst_s) begin
         config_reg <= `CIO_CONFIG_RST;
         io_base <= `CIO_IOBASE_RST;
         sig_enable <= 1'b0;
      end else begin
         if (wr_cfg) begin
            config_reg <= reg_wdata;
         end
         if (wr_iob) begin
            io_base <= reg_wdata;
         end
         if (wr_sts) begin
            sig_enable <= reg_wdata[`CIO_STS_SIGEN];
         end
      end
   end

   // ***********************************
   // Change bits and pending interrupt
   // ***********************************
   wire [3:0] cur_levels = {ready_busy_in, wprot_in, battery_detect_2, battery_detect_1};
   wire [3:0] level_edges = cur_levels ^ prev_levels;
   // Set wins over a write-one-to-clear in the same cycle
   wire [3:0] next_change = level_edges | (change_bits & ~(wr_pin ? reg_wdata[3:0] : 4'h0));
   wire changed_sum = |change_bits;
   wire clr_int = wr_sts && reg_wdata[`CIO_STS_INTPEND];
   wire next_pending = irq_request || (int_pending && !clr_int);

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         change_bits <= 4'h0;
         // Seeded with live levels so reset flags no false change
         prev_levels <= cur_levels;
         int_pending <= 1'b0;
      end else begin
         change_bits <= next_change;
         prev_levels <= cur_levels;
         int_pending <= next_pending;
      end
   end

   // ***********************************
   // Pulsed interrupt timer
   // ***********************************
   cio_irq_state_e irq_state;
   cio_irq_state_e next_irq_state;
   logic [4:0] pulse_cnt;
   wire pend_rise = next_pending && !int_pending;

   always_comb begin
      next_irq_state = irq_state;
      case (irq_state)
         CIO_IRQ_IDLE: begin
            if (pend_rise && !level_mode && io_mode) begin
               next_irq_state = CIO_IRQ_PULSE;
            end
         end
         CIO_IRQ_PULSE: begin
            if (pulse_cnt == PULSE_CYC) begin
               next_irq_state = CIO_IRQ_IDLE;
            end
         end
         default: begin
            next_irq_state = CIO_IRQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         irq_state <= CIO_IRQ_IDLE;
         pulse_cnt <= 5'd0;
      end else begin
         irq_state <= next_irq_state;
         pulse_cnt <= (next_irq_state == CIO_IRQ_PULSE) ? pulse_cnt + 5'd1 : 5'd0;
      end
   end

   // ***********************************
   // Pin function selection
   // ***********************************
   // Level mode low until software clears pending; pulsed low for timer
   wire irq_active = level_mode ? int_pending : (next_irq_state == CIO_IRQ_PULSE);
   wire next_pin16 = io_mode ? !(irq_active && io_mode) : ready_busy_in;
   wire audio_on = AUDIO_SUPPORT && audio_enable && audio_in;
   wire next_audio = io_mode ? !audio_on : battery_detect_2;
   wire sts_low = STATUS_SUPPORT && sig_enable && changed_sum;
   wire next_status_n = io_mode ? !sts_low : battery_detect_1;

   // I/O decode: upper address bits against base register
   wire io_sel = io_mode && !reg_n_s && !(lo_en_n_s && hi_en_n_s);
   wire io_match = io_sel && (ioa_s[IO_AW-1:IO_AW-8] == io_base);
   wire next_wide_n = !(io_match && WIDE_PORT);
   wire next_ack_n = !(io_match && !iord_n_s);

   // Common memory read steering
   wire mem_rd = reg_n_s && !oe_n_s;
   wire next_oe_lo = mem_rd && !lo_en_n_s;
   wire next_oe_hi = mem_rd && !hi_en_n_s;
   wire [7:0] next_lo = (hi_en_n_s && byte_sel_s) ? mem_odd_byte : mem_even_byte;
   wire [15:0] next_data = {next_oe_hi ? mem_odd_byte : 8'h00, next_oe_lo ? next_lo : 8'h00};

   // Registered pins: mode switch lands on one edge
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ready_busy_line <= 1'b1;
         binary_audio_n <= 1'b1;
         status_changed_n <= 1'b1;
         wide_port_ind_n <= 1'b1;
         input_ack_n <= 1'b1;
         data_out <= 16'h0000;
         data_oe_lo <= 1'b0;
         data_oe_hi <= 1'b0;
      end else begin
         ready_busy_line <= next_pin16;
         binary_audio_n <= next_audio;
         status_changed_n <= next_status_n;
         wide_port_ind_n <= next_wide_n;
         input_ack_n <= next_ack_n;
         data_out <= next_data;
         data_oe_lo <= next_oe_lo;
         data_oe_hi <= next_oe_hi;
      end
   end

   // ***********************************
   // Register read
   // ***********************************
   cio_byte_t next_rdata;
   wire [7:0] sts_word = {5'h00, int_pending, changed_sum, sig_enable};
   assign next_rdata = !reg_rd ? 8'h00 :
      hit(reg_addr, `CIO_OFS_CONFIG) ? config_reg :
      hit(reg_addr, `CIO_OFS_STATUS) ? sts_word :
      hit(reg_addr, `CIO_OFS_PINREP) ? {cur_levels, change_bits} :
      hit(reg_addr, `CIO_OFS_IOBASE) ? io_base : 8'h00;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ***********************************
   // Assertions
   // ***********************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   logic [5:0] low_run;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         low_run <= 6'd0;
      end else begin
         low_run <= ready_busy_line ? 6'd0 : ((low_run == 6'h3f) ? low_run : low_run + 6'd1);
      end
   end

   property p_pulse_width;
      $rose(ready_busy_line) && $past(io_mode) && !$past(level_mode) && $past(io_mode, 2)
         |-> low_run >= 6'(PULSE_CYC);
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("irq pulse too short");

   property p_level_hold;
      io_mode && level_mode && int_pending && !clr_int ##1 io_mode && level_mode
         |=> !ready_busy_line;
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level irq released early");

   property p_idle_high;
      io_mode && !int_pending && irq_state == CIO_IRQ_IDLE && !irq_request
         ##1 io_mode && !int_pending |-> ready_busy_line;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("irq low with none pending");

   property p_memonly_pins;
      !io_mode |=> ready_busy_line == $past(ready_busy_in)
         && binary_audio_n == $past(battery_detect_2)
         && status_changed_n == $past(battery_detect_1);
   endproperty
   a_memonly_pins: assert property (p_memonly_pins) else $error("memory-only pins wrong");

   property p_status_chg;
      io_mode && sig_enable && STATUS_SUPPORT |=> status_changed_n == !$past(changed_sum);
   endproperty
   a_status_chg: assert property (p_status_chg) else $error("status changed mismatch");

   property p_status_off;
      io_mode && !sig_enable |=> status_changed_n;
   endproperty
   a_status_off: assert property (p_status_off) else $error("status changed not high");

   property p_audio_gate;
      io_mode && !audio_enable |=> binary_audio_n;
   endproperty
   a_audio_gate: assert property (p_audio_gate) else $error("audio not gated");

   property p_standby;
      lo_en_n_s && hi_en_n_s |=> !data_oe_lo && !data_oe_hi;
   endproperty
   a_standby: assert property (p_standby) else $error("bus driven in standby");

   property p_word;
      mem_rd && !lo_en_n_s && !hi_en_n_s
         |=> data_out == {$past(mem_odd_byte), $past(mem_even_byte)};
   endproperty
   a_word: assert property (p_word) else $error("word read lanes wrong");

   property p_byte_read;
      mem_rd && !lo_en_n_s && hi_en_n_s |=> data_oe_lo && !data_oe_hi
         && data_out[7:0] == ($past(byte_sel_s) ? $past(mem_odd_byte) : $past(mem_even_byte));
   endproperty
   a_byte_read: assert property (p_byte_read) else $error("byte read lanes wrong");

   property p_odd_only;
      mem_rd && lo_en_n_s && !hi_en_n_s |=> !data_oe_lo && data_oe_hi
         && data_out[15:8] == $past(mem_odd_byte);
   endproperty
   a_odd_only: assert property (p_odd_only) else $error("odd byte lanes wrong");

   property p_ack_unconf;
      !io_mode |=> input_ack_n && wide_port_ind_n;
   endproperty
   a_ack_unconf: assert property (p_ack_unconf) else $error("ack while unconfigured");

   property p_reset_clears;
      rst_s |=> config_reg == `CIO_CONFIG_RST;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("card reset kept config");

   c_pulse: cover property (io_mode && !level_mode ##1 $rose(ready_busy_line));
   c_level: cover property (io_mode && level_mode && clr_int ##1 ready_busy_line);
   c_byte_odd: cover property (mem_rd && !lo_en_n_s && hi_en_n_s && byte_sel_s);
   c_status_chg: cover property (io_mode && sig_enable && $fell(status_changed_n));

endmodule : cio_card_io
`default_nettype wire

// *** cio_host_model.sv ***
// Purpose: Host socket controller model driving the card pins
// Assumes: Pins change just after a rising clock edge
// Notes: Idle strobes sit inactive high; card reset idles low
`timescale 1ns/100ps
`default_nettype none
module cio_host_model (
   input wire logic ref_clk,
   input wire logic ready_busy_line,
   input wire logic binary_audio_n,
   input wire logic sys_speaker,
   output logic card_reset,
   output logic low_byte_enable_n,
   output logic high_byte_enable_n,
   output logic byte_addr_bit,
   output logic attr_select_n,
   output logic out_enable_n,
   output logic io_read_n,
   output logic [9:0] io_addr,
   output logic speaker,
   output logic [7:0] irq_seen
);
   logic last_irq;
   // Loudspeaker mix of card audio and own source
   assign speaker = binary_audio_n ^ sys_speaker;
   initial begin
      card_reset = 1'b0;
      low_byte_enable_n = 1'b1;
      high_byte_enable_n = 1'b1;
      byte_addr_bit = 1'b0;
      attr_select_n = 1'b1;
      out_enable_n = 1'b1;
      io_read_n = 1'b1;
      io_addr = 10'h155;
      irq_seen = 8'h00;
      last_irq = 1'b1;
   end
   // Interrupt counted on the trailing rise only
   always @(posedge ref_clk) begin
      if (ready_busy_line && !last_irq) begin
         irq_seen <= irq_seen + 8'h01;
      end
      last_irq <= ready_busy_line;
   end
   // *************
   // Host cycles
   // *************
   task automatic mem_read(input logic lo_n, input logic hi_n, input logic sel);
      attr_select_n <= 1'b1;
      out_enable_n <= 1'b0;
      low_byte_enable_n <= lo_n;
      high_byte_enable_n <= hi_n;
      byte_addr_bit <= sel;
   endtask : mem_read
   // Without wide indication a 16-bit access goes as byte references
   task automatic io_rd(input logic [9:0] addr, input logic wide);
      attr_select_n <= 1'b0;
      io_read_n <= 1'b0;
      low_byte_enable_n <= 1'b0;
      high_byte_enable_n <= !wide;
      byte_addr_bit <= wide ? 1'b0 : addr[0];
      io_addr <= addr;
   endtask : io_rd
   // Released address bus must not keep its last value
   task automatic idle;
      attr_select_n <= 1'b1;
      out_enable_n <= 1'b1;
      io_read_n <= 1'b1;
      low_byte_enable_n <= 1'b1;
      high_byte_enable_n <= 1'b1;
      io_addr <= ~io_addr;
   endtask : idle
   task automatic set_reset(input logic v);
      card_reset <= v;
   endtask : set_reset
endmodule : cio_host_model
`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for the card pin block
// Assumes: 25 MHz clock, default block parameters
// Notes: Host pins come from the host model
`timescale 1ns/100ps
`default_nettype none
`include "cio_regs.svh"
module testbench;
   import cio_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   cio_byte_t reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic irq_request = 1'b0;
   logic audio_in = 1'b0;
   logic ready_busy_in = 1'b0;
   logic battery_detect_1 = 1'b0;
   logic battery_detect_2 = 1'b1;
   logic wprot_in = 1'b0;
   cio_byte_t mem_even_byte = 8'h5A;
   cio_byte_t mem_odd_byte = 8'hC3;
   logic sys_speaker = 1'b1;
   cio_byte_t reg_rdata;
   logic card_reset, low_byte_enable_n, high_byte_enable_n, byte_addr_bit;
   logic attr_select_n, out_enable_n, io_read_n, speaker;
   logic [9:0] io_addr;
   logic [7:0] irq_seen;
   logic [7:0] seen_before;
   logic wide_port_ind_n, ready_busy_line, binary_audio_n, status_changed_n;
   logic input_ack_n, data_oe_lo, data_oe_hi;
   logic [15:0] data_out;
   wire logic [4:0] pins;
   logic [20:0] rows [0:6];
   int errors = 0;
   int tests_run = 0;
   int n;
   assign pins = {ready_busy_line, binary_audio_n, status_changed_n, input_ack_n, wide_port_ind_n};
   always #20 ref_clk = ~ref_clk;
   cio_card_io u_cio_card_io (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq_request, .audio_in, .ready_busy_in, .battery_detect_1,
      .battery_detect_2, .wprot_in, .mem_even_byte, .mem_odd_byte,
      .card_reset, .low_byte_enable_n, .high_byte_enable_n, .byte_addr_bit, .attr_select_n,
      .out_enable_n, .io_read_n, .io_addr, .wide_port_ind_n, .ready_busy_line,
      .binary_audio_n, .status_changed_n, .input_ack_n, .data_out, .data_oe_lo, .data_oe_hi);
   cio_host_model u_cio_host_model (.ref_clk, .ready_busy_line, .binary_audio_n,
      .sys_speaker, .card_reset, .low_byte_enable_n, .high_byte_enable_n,
      .byte_addr_bit, .attr_select_n, .out_enable_n, .io_read_n, .io_addr, .speaker,
      .irq_seen);
   // ***************
   // Helper tasks
   // ***************
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic pchk(input string what, input logic [4:0] exp);
      chk(what, {11'h000, pins}, {11'h000, exp});
   endtask : pchk
   task automatic wr(input logic [3:0] a, input cio_byte_t d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      cyc(1);
      reg_wr <= 1'b0;
      cyc(2);
   endtask : wr
   task automatic rd(input string what, input logic [3:0] a, input cio_byte_t exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      chk(what, {8'h00, reg_rdata}, {8'h00, exp});
      cyc(1);
   endtask : rd
   task automatic stop_test;
      $display("Checks run %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // ***************
   // Main sequence
   // ***************
   initial begin
      // Rows: low enable, high enable, byte bit, oe_hi, oe_lo, data lanes
      rows[0] = {3'b110, 2'b00, 16'h0000};
      rows[1] = {3'b010, 2'b01, 16'h005A};
      rows[2] = {3'b011, 2'b01, 16'h00C3};
      rows[3] = {3'b000, 2'b11, 16'hC35A};
      rows[4] = {3'b001, 2'b11, 16'hC35A};
      rows[5] = {3'b100, 2'b10, 16'hC300};
      rows[6] = {3'b101, 2'b10, 16'hC300};
      cyc(12);
      pchk("pins_in_reset", 5'h1F);
      reset_n <= 1'b1;
      cyc(4);
      pchk("pins_mem_only", 5'h0B);
      for (n = 0; n < 7; n++) begin
         u_cio_host_model.mem_read(rows[n][20], rows[n][19], rows[n][18]);
         cyc(4);
         chk("data_lanes", data_out, rows[n][15:0]);
         chk("lane_enables", {14'h0000, data_oe_hi, data_oe_lo}, {14'h0000, rows[n][17:16]});
      end
      mem_even_byte <= 8'hA6;
      mem_odd_byte <= 8'h3C;
      u_cio_host_model.mem_read(1'b0, 1'b0, 1'b1);
      cyc(4);
      chk("word_new_data", data_out, 16'h3CA6);
      u_cio_host_model.idle();
      rd("unmapped", 4'hF, 8'h00);
      rd("config_reset", `CIO_OFS_CONFIG, `CIO_CONFIG_RST);
      wr(`CIO_OFS_IOBASE, 8'h40);
      u_cio_host_model.io_rd(10'h101, 1'b0);
      cyc(4);
      pchk("ack_unconfigured", 5'h0B);
      u_cio_host_model.idle();
      audio_in <= 1'b1;
      wr(`CIO_OFS_CONFIG, 8'h0D);
      cyc(1);
      pchk("io_idle", 5'h17);
      chk("speaker_mix", {15'h0000, speaker}, 16'h0001);
      sys_speaker <= 1'b0;
      cyc(1);
      chk("speaker_own_off", {15'h0000, speaker}, 16'h0000);
      u_cio_host_model.io_rd(10'h100, 1'b1);
      cyc(4);
      pchk("io_hit", 5'h14);
      u_cio_host_model.idle();
      wr(`CIO_OFS_PINREP, 8'h0F);
      wr(`CIO_OFS_STATUS, 8'h01);
      for (n = 0; n < 4; n++) begin
         case (n)
            0: battery_detect_1 <= ~battery_detect_1;
            1: battery_detect_2 <= ~battery_detect_2;
            2: wprot_in <= ~wprot_in;
            default: ready_busy_in <= ~ready_busy_in;
         endcase
         cyc(4);
         chk("chg_low", {15'h0000, status_changed_n}, 16'h0000);
         rd("status_chg", `CIO_OFS_STATUS, 8'h03);
         wr(`CIO_OFS_PINREP, 8'(1 << n));
         chk("chg_high", {15'h0000, status_changed_n}, 16'h0001);
      end
      wr(`CIO_OFS_STATUS, 8'h00);
      wprot_in <= ~wprot_in;
      cyc(4);
      chk("chg_masked", {15'h0000, status_changed_n}, 16'h0001);
      wr(`CIO_OFS_PINREP, 8'h0F);
      wr(`CIO_OFS_CONFIG, 8'h05);
      chk("audio_gated", {15'h0000, binary_audio_n}, 16'h0001);
      chk("speaker_gated", {15'h0000, speaker}, 16'h0001);
      irq_request <= 1'b1;
      cyc(1);
      irq_request <= 1'b0;
      cyc(22);
      chk("level_held", {15'h0000, ready_busy_line}, 16'h0000);
      rd("pending", `CIO_OFS_STATUS, 8'h04);
      wr(`CIO_OFS_STATUS, 8'h04);
      chk("level_done", {15'h0000, ready_busy_line}, 16'h0001);
      wr(`CIO_OFS_CONFIG, 8'h01);
      seen_before = irq_seen;
      irq_request <= 1'b1;
      cyc(1);
      irq_request <= 1'b0;
      n = 0;
      while (ready_busy_line !== 1'b0 && n < 8) begin
         cyc(1);
         n++;
      end
      chk("pulse_started", {15'h0000, ready_busy_line}, 16'h0000);
      if (n == 8) begin
         stop_test();
      end
      n = 0;
      while (ready_busy_line === 1'b0 && n < 40) begin
         cyc(1);
         n++;
      end
      chk("pulse_len", 16'(n), 16'h000D);
      if (n == 40) begin
         stop_test();
      end
      cyc(2);
      chk("irq_taken", {8'h00, irq_seen - seen_before}, 16'h0001);
      wr(`CIO_OFS_STATUS, 8'h04);
      u_cio_host_model.set_reset(1'b1);
      cyc(4);
      u_cio_host_model.set_reset(1'b0);
      cyc(4);
      pchk("card_reset", {ready_busy_in, battery_detect_2, battery_detect_1, 2'b11});
      rd("config_cleared", `CIO_OFS_CONFIG, 8'h00);
      reset_n <= 1'b0;
      cyc(2);
      pchk("mid_reset", 5'h1F);
      reset_n <= 1'b1;
      cyc(3);
      stop_test();
   end
endmodule : testbench
`default_nettype wire
